// ---- verilog/sar_adc_conversion_control.sv ----
// control logic of a 10-bit successive-approximation converter
// Operation
// R1 - result is 10-bit unsigned, ground to reference
// R2 - reference_select picks supply, external or internal
// R3 - channel select picks input and differential gain
// R4 - differential gain 1x/20x, single-ended bypasses gain
// R5 - code 100010 selects temperature sensor
// R6 - selections apply only while converter enabled
// R7 - right aligned result, left when adjust set
// R8 - low byte read locks result until high
// R9 - completion flag raised even when result lost
// R10 - software reads low byte before high byte
// R11 - start bit begins conversion, cleared at end
// R12 - channel change waits for current conversion end
// R13 - auto trigger starts conversions from chosen source
// R14 - trigger rising edge resets prescaler, starts conversion
// R15 - held level or busy edges start nothing
// R16 - trigger flags set regardless of interrupt enables
// R17 - software clears trigger flag before next event
// R18 - done flag source gives free running
// R19 - software starts first free-running conversion
// R20 - start bit still works with auto trigger
// R21 - start bit reads one during any conversion
// R22 - dedicated interrupt request on completion
// R23 - 13 converter cycles, first one 25
// R24 - completion writes result, sets flag, clears start
// R25 - prescaler runs only while converter enabled
// R26 - done flag clears by write one or service
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps

module sar_adc_conversion_control #(
	parameter int PRESC_DIV = sar_ctl_pkg::PRESC_DIV_DEF
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// register port
	input wire logic [sar_ctl_pkg::ADDR_W-1:0] ADDR,
	input wire logic [sar_ctl_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [sar_ctl_pkg::DATA_W-1:0] RDATA,
	// trigger flags and interrupt service
	input wire logic [sar_ctl_pkg::NUM_TRIG-1:0] TRIG_IN,
	input wire logic IRQ_ACK,
	output logic IRQ,
	// successive-approximation datapath
	input wire logic [sar_ctl_pkg::RES_W-1:0] SAR_RESULT,
	output sar_ctl_pkg::front_end_t FRONT_END,
	output logic CONV_START,
	output logic CONV_BUSY
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	sar_ctl_pkg::conv_state_t state_reg, state_next;
	sar_ctl_pkg::mux_sel_t temp_sel_reg;
	sar_ctl_pkg::mux_sel_t sel_reg;
	logic en_reg, start_reg, auto_reg, done_reg, ie_reg, ladj_reg, lock_reg, first_reg;
	logic [sar_ctl_pkg::TRIG_W-1:0] trig_sel_reg;
	logic [sar_ctl_pkg::RES_W-1:0] result_reg;
	logic [sar_ctl_pkg::CNT_W-1:0] cnt_reg;
	logic [$clog2(PRESC_DIV)-1:0] presc_reg;
	logic trig_prev_reg;
	logic tick, last_tick, complete, free_mode, trig_level, trig_edge, trig_start, sw_start;
	logic wr_a, wr_mux, rd_low, rd_high;
	logic [sar_ctl_pkg::DATA_W-1:0] rd_mux;
	logic [15:0] aligned;

	// cycles of the running conversion, less one
	function automatic logic [sar_ctl_pkg::CNT_W-1:0] conv_last(input logic first);
		conv_last = first ? sar_ctl_pkg::CNT_W'(sar_ctl_pkg::FIRST_CYCLES - 1)
			: sar_ctl_pkg::CNT_W'(sar_ctl_pkg::NORMAL_CYCLES - 1);
	endfunction

	// result placed in a 16-bit pair of bytes
	function automatic logic [15:0] align(input logic [sar_ctl_pkg::RES_W-1:0] v,
		input logic ladj);
		align = ladj ? {v, 6'h00} : {6'h00, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus decode and event terms
	assign wr_a = WR && (ADDR == sar_ctl_pkg::CTRLA_IDX);
	assign wr_mux = WR && (ADDR == sar_ctl_pkg::MUX_IDX);
	assign rd_low = RD && (ADDR == sar_ctl_pkg::RESL_IDX);
	assign rd_high = RD && (ADDR == sar_ctl_pkg::RESH_IDX);
	assign tick = en_reg && (presc_reg == ($clog2(PRESC_DIV))'(PRESC_DIV - 1));
	assign last_tick = (state_reg == sar_ctl_pkg::ST_CONV) && tick
		&& (cnt_reg == conv_last(first_reg));
	// R23 conversion length count
	assign complete = last_tick;
	// R18 done flag source
	assign free_mode = auto_reg && (trig_sel_reg == sar_ctl_pkg::TRIG_FREE);
	assign trig_level = TRIG_IN[trig_sel_reg];
	// R13 selected trigger edge
	assign trig_edge = auto_reg && !free_mode && trig_level && !trig_prev_reg;
	// R15 busy edges ignored
	assign trig_start = en_reg && trig_edge && (state_reg == sar_ctl_pkg::ST_IDLE);
	// R11 R20 software start
	assign sw_start = en_reg && wr_a && WDATA[sar_ctl_pkg::START_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			sar_ctl_pkg::ST_IDLE: begin
				if (trig_start) begin
					state_next = sar_ctl_pkg::ST_CONV;
				end else if (sw_start) begin
					state_next = sar_ctl_pkg::ST_WAIT;
				end
			end
			sar_ctl_pkg::ST_WAIT: begin
				if (tick) begin
					state_next = sar_ctl_pkg::ST_CONV;
				end
			end
			sar_ctl_pkg::ST_CONV: begin
				// R18 restart at once in free running
				if (complete && !free_mode) begin
					state_next = sar_ctl_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = sar_ctl_pkg::ST_IDLE;
			end
		endcase
		if (!en_reg) begin
			state_next = sar_ctl_pkg::ST_IDLE;
		end
	end

	// sequencer state
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= sar_ctl_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// converter cycle count within a conversion
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_reg <= '0;
		end else if (state_reg != sar_ctl_pkg::ST_CONV || complete) begin
			cnt_reg <= '0;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// R23 first conversion after enabling is long
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			first_reg <= 1'b1;
		end else if (!en_reg) begin
			first_reg <= 1'b1;
		end else if (complete) begin
			first_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// R25 prescaler held while disabled
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			presc_reg <= '0;
		end else if (!en_reg || trig_start || tick) begin
			// R14 trigger restarts prescaler
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// trigger level history for edge detection
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			trig_prev_reg <= 1'b0;
		end else begin
			trig_prev_reg <= trig_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register a
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			en_reg <= 1'b0;
			auto_reg <= 1'b0;
			ie_reg <= 1'b0;
		end else if (wr_a) begin
			en_reg <= WDATA[sar_ctl_pkg::EN_BIT];
			auto_reg <= WDATA[sar_ctl_pkg::AUTO_BIT];
			ie_reg <= WDATA[sar_ctl_pkg::IE_BIT];
		end
	end

	// R21 start bit mirrors busy; clear beats a late start write
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_reg <= 1'b0;
		end else if (!en_reg) begin
			start_reg <= 1'b0;
		end else if (complete && !free_mode) begin
			// R24 R11 cleared on single completion
			start_reg <= 1'b0;
		end else if (sw_start || trig_start) begin
			start_reg <= 1'b1;
		end
	end

	// R16 R24 done flag set whatever the enables; set wins
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_reg <= 1'b0;
		end else if (complete) begin
			// R9 raised even when result is lost
			done_reg <= 1'b1;
		end else if ((wr_a && WDATA[sar_ctl_pkg::DONE_BIT]) || IRQ_ACK) begin
			// R26 write one or service clears
			done_reg <= 1'b0;
		end
	end

	// control register b
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ladj_reg <= 1'b0;
			trig_sel_reg <= sar_ctl_pkg::TRIG_FREE;
		end else if (WR && ADDR == sar_ctl_pkg::CTRLB_IDX) begin
			ladj_reg <= WDATA[sar_ctl_pkg::LADJ_BIT];
			trig_sel_reg <= WDATA[sar_ctl_pkg::TRIG_LSB +: sar_ctl_pkg::TRIG_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software copy of the selection, freely written
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			temp_sel_reg <= '0;
		end else if (wr_mux) begin
			temp_sel_reg.ref_sel <= WDATA[sar_ctl_pkg::REF_LSB +: 2];
			temp_sel_reg.chan <= WDATA[sar_ctl_pkg::CHAN_LSB +: 6];
		end
	end

	// R6 R12 working selection follows only when enabled and safe
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_reg <= '0;
		end else if (en_reg && (state_reg != sar_ctl_pkg::ST_CONV || last_tick)) begin
			sel_reg <= temp_sel_reg;
		end
	end

	// R2 R3 front end controls derived from working selection, active flag from enable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FRONT_END <= '0;
		end else begin
			FRONT_END.ref_sel <= sel_reg.ref_sel;
			FRONT_END.chan <= sel_reg.chan;
			// R5 temperature sensor code
			FRONT_END.temp_sel <= (sel_reg.chan == sar_ctl_pkg::TEMP_CODE);
			// R4 gain bypass for single-ended inputs
			FRONT_END.gain_bypass <= (sel_reg.chan <= sar_ctl_pkg::SE_LAST_CODE)
				|| (sel_reg.chan == sar_ctl_pkg::TEMP_CODE);
			FRONT_END.gain_20x <= sel_reg.chan[0] && (sel_reg.chan > sar_ctl_pkg::SE_LAST_CODE)
				&& (sel_reg.chan != sar_ctl_pkg::TEMP_CODE);
			FRONT_END.active <= en_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// R8 lock set by low read, released by high read
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_reg <= 1'b0;
		end else if (rd_high) begin
			lock_reg <= 1'b0;
		end else if (rd_low) begin
			lock_reg <= 1'b1;
		end
	end

	// R1 R8 result captured unless locked
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			result_reg <= '0;
		end else if (complete && !lock_reg) begin
			result_reg <= SAR_RESULT;
		end
	end

	// R7 result bytes in the chosen alignment
	assign aligned = align(result_reg, ladj_reg);

	// read data selection
	always_comb begin
		rd_mux = sar_ctl_pkg::ZERO_BYTE;
		unique case (ADDR)
			sar_ctl_pkg::MUX_IDX: rd_mux = {temp_sel_reg.ref_sel, temp_sel_reg.chan};
			sar_ctl_pkg::CTRLA_IDX: rd_mux = {en_reg, start_reg, auto_reg, done_reg,
				ie_reg, 3'h0};
			sar_ctl_pkg::CTRLB_IDX: rd_mux = {3'h0, ladj_reg, 1'b0, trig_sel_reg};
			// R7 alignment of the result bytes
			sar_ctl_pkg::RESL_IDX: rd_mux = aligned[7:0];
			sar_ctl_pkg::RESH_IDX: rd_mux = aligned[15:8];
			default: rd_mux = sar_ctl_pkg::ZERO_BYTE;
		endcase
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= sar_ctl_pkg::ZERO_BYTE;
		end else begin
			RDATA <= RD ? rd_mux : sar_ctl_pkg::ZERO_BYTE;
		end
	end

	// R22 interrupt request and datapath strobes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
			CONV_START <= 1'b0;
			CONV_BUSY <= 1'b0;
		end else begin
			IRQ <= done_reg && ie_reg && !IRQ_ACK;
			CONV_START <= (state_next == sar_ctl_pkg::ST_CONV)
				&& (state_reg != sar_ctl_pkg::ST_CONV || complete);
			CONV_BUSY <= (state_next == sar_ctl_pkg::ST_CONV);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_done_on_complete: assert property (complete |=> done_reg) // R24
		else $error("done flag not set at completion");
	a_single_clears_start: assert property (complete && !free_mode
		|=> !start_reg) // R11
		else $error("start bit not cleared after single conversion");
	a_start_while_busy: assert property (state_reg == sar_ctl_pkg::ST_CONV |-> start_reg) // R21
		else $error("start bit low during conversion");
	a_locked_result_kept: assert property (lock_reg && !rd_high && complete
		|=> $stable(result_reg) && done_reg) // R8
		else $error("locked result changed or flag missing");
	a_lost_result_flag: assert property (lock_reg && complete |=> done_reg) // R9
		else $error("flag missing for lost result");
	a_sel_frozen_conv: assert property (state_reg == sar_ctl_pkg::ST_CONV && !last_tick
		|=> $stable(sel_reg)) // R12
		else $error("selection changed during conversion");
	a_sel_disabled_hold: assert property (!en_reg |=> $stable(sel_reg)) // R6
		else $error("selection changed while disabled");
	a_presc_held_off: assert property (!en_reg |=> presc_reg == '0 && !tick) // R25
		else $error("prescaler running while disabled");
	a_trig_starts: assert property (trig_start |=> state_reg == sar_ctl_pkg::ST_CONV
		&& presc_reg == '0 ##1 start_reg) // R14
		else $error("trigger edge did not start conversion");
	a_free_restart: assert property (complete && free_mode && en_reg
		|=> state_reg == sar_ctl_pkg::ST_CONV && start_reg) // R18
		else $error("free running did not restart");
	a_gain_bypass: assert property (FRONT_END.gain_bypass |-> !FRONT_END.gain_20x) // R4
		else $error("gain applied to single-ended input");
	a_temp_route: assert property (sel_reg.chan == sar_ctl_pkg::TEMP_CODE
		|=> FRONT_END.temp_sel) // R5
		else $error("temperature sensor not routed");
	a_read_pulse: assert property (!RD |=> RDATA == sar_ctl_pkg::ZERO_BYTE)
		else $error("read data outside read cycle");

	c_trig_conv: cover property (trig_start ##[1:400] complete);
	c_free_two: cover property (complete && free_mode ##[1:1000] complete);
	c_lost_result: cover property (lock_reg && complete);
	c_first_conv: cover property (complete && first_reg);

endmodule // sar_adc_conversion_control

// ---- pkg/sar_ctl_pkg.sv ----
// shared constants, types and register map of the converter control block
package sar_ctl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register bus and register indices
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] MUX_IDX = 3'h0;
	localparam logic [ADDR_W-1:0] CTRLA_IDX = 3'h1;
	localparam logic [ADDR_W-1:0] CTRLB_IDX = 3'h2;
	localparam logic [ADDR_W-1:0] RESL_IDX = 3'h3;
	localparam logic [ADDR_W-1:0] RESH_IDX = 3'h4;

	// converter_control_a field positions
	localparam int EN_BIT = 7;
	localparam int START_BIT = 6;
	localparam int AUTO_BIT = 5;
	localparam int DONE_BIT = 4;
	localparam int IE_BIT = 3;
	// converter_control_b field positions
	localparam int LADJ_BIT = 4;
	localparam int TRIG_LSB = 0;
	localparam int TRIG_W = 3;
	// input_mux_register field positions
	localparam int REF_LSB = 6;
	localparam int CHAN_LSB = 0;

	////////////////////////////////////////////////////////////////////////////////
	// conversion figures
	localparam int RES_W = 10;
	localparam int NORMAL_CYCLES = 13;
	localparam int FIRST_CYCLES = 25;
	localparam int PRESC_DIV_DEF = 8;
	localparam int CNT_W = 5;
	localparam int NUM_TRIG = 8;

	// channel and reference codes
	localparam logic [5:0] SE_LAST_CODE = 6'h07;
	localparam logic [5:0] TEMP_CODE = 6'h22;
	localparam logic [1:0] REF_VCC = 2'h0;
	localparam logic [1:0] REF_EXT = 2'h1;
	localparam logic [1:0] REF_INT = 2'h2;
	localparam logic [2:0] TRIG_FREE = 3'h0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} conv_state_t;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [5:0] chan;
	} mux_sel_t;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [5:0] chan;
		logic gain_20x;
		logic gain_bypass;
		logic temp_sel;
		logic active;
	} front_end_t;

endpackage

// ---- testbench/tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/100ps

module tb;
	localparam int P = 2;
	localparam logic [7:0] EN = 8'(1 << sar_ctl_pkg::EN_BIT);
	localparam logic [7:0] GO = 8'(1 << sar_ctl_pkg::START_BIT);
	localparam logic [7:0] AU = 8'(1 << sar_ctl_pkg::AUTO_BIT);
	localparam logic [7:0] DN = 8'(1 << sar_ctl_pkg::DONE_BIT);
	localparam logic [7:0] IE = 8'(1 << sar_ctl_pkg::IE_BIT);
	localparam logic [7:0] LA = 8'(1 << sar_ctl_pkg::LADJ_BIT);
	// clock, reset and register port
	logic CLK, RST_N, WR, RD, IRQ_ACK, IRQ, CONV_START, CONV_BUSY;
	logic [sar_ctl_pkg::ADDR_W-1:0] ADDR;
	logic [7:0] WDATA, RDATA, TRIG_IN;
	logic [9:0] SAR_RESULT, r;
	logic [5:0] code;
	logic [1:0] rf;
	sar_ctl_pkg::front_end_t FRONT_END;
	logic [31:0] lfsr;
	int num_errors, n_tests, len, i, s0, starts, cyc, t0;

	sar_adc_conversion_control #(.PRESC_DIV(P)) sar_adc_conversion_control_i (.CLK(CLK),
		.RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.TRIG_IN(TRIG_IN), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ), .SAR_RESULT(SAR_RESULT),
		.FRONT_END(FRONT_END), .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY));

	////////////////////////////////////////////////////////////////////////////////
	// clock and start-pulse counter
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (CONV_START === 1'b1) starts++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers: random source, expectations, bus cycles, waits
	function automatic logic [31:0] step(logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
	endfunction
	function automatic logic [7:0] exp_lo(logic [9:0] v, logic l);
		return l ? {v[1:0], 6'h00} : v[7:0];
	endfunction
	function automatic logic [7:0] exp_hi(logic [9:0] v, logic l);
		return l ? v[9:2] : {6'h00, v[9:8]};
	endfunction
	task chk(string name, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(logic [2:0] a, logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task rdc(logic [2:0] a, logic [7:0] exp, string name);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk(name, exp, RDATA);
	endtask
	task tick(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task trig(logic [7:0] v);
		@(posedge CLK);
		TRIG_IN <= v;
	endtask
	task wait_start(int lim);
		i = 0;
		#1;
		while (CONV_START !== 1'b1 && i < lim) begin
			tick(1);
			i++;
		end
		t0 = cyc;
		chk("conversion started", 1, i < lim);
	endtask
	// len ends as busy cycles counted from the start pulse
	task wait_end();
		len = 0;
		while (CONV_BUSY === 1'b1 && len < 400) begin
			tick(1);
			len++;
		end
		len = cyc - t0;
		tick(3);
	endtask
	task no_start(int n);
		s0 = starts;
		tick(n);
		chk("no new conversion", s0, starts);
	endtask
	task results();
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{RST_N, WR, RD, IRQ_ACK, ADDR, WDATA, TRIG_IN} = '0;
		SAR_RESULT = 10'h000;
		lfsr = 32'hb0fc_c91f;
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		for (int a = 0; a < 6; a++) rdc(3'(a), 8'h00, "reset value");
		wr(sar_ctl_pkg::MUX_IDX, 8'h85);
		wr(sar_ctl_pkg::CTRLA_IDX, GO);
		tick(3);
		chk("front end inactive", 0, FRONT_END.active);
		rdc(sar_ctl_pkg::CTRLA_IDX, 8'h00, "start refused");
		rdc(sar_ctl_pkg::MUX_IDX, 8'h85, "mux readback");
		wr(sar_ctl_pkg::CTRLA_IDX, EN);
		tick(3);
		chk("chan after enable", 6'h05, FRONT_END.chan);
		chk("front end active", 1, FRONT_END.active);
		// front-end encoding, random codes plus the sensor
		for (int k = 0; k < 14; k++) begin
			lfsr = step(lfsr);
			code = (k == 13) ? sar_ctl_pkg::TEMP_CODE : lfsr[5:0];
			rf = lfsr[7:6];
			wr(sar_ctl_pkg::MUX_IDX, {rf, code});
			tick(3);
			chk("reference", rf, FRONT_END.ref_sel);
			chk("channel", code, FRONT_END.chan);
			chk("sensor", code == sar_ctl_pkg::TEMP_CODE, FRONT_END.temp_sel);
			if (code != sar_ctl_pkg::TEMP_CODE) chk("bypass", code <= 6'h07, FRONT_END.gain_bypass);
			if (code > 6'h07 && code != sar_ctl_pkg::TEMP_CODE) chk("gain", code[0], FRONT_END.gain_20x);
		end
		// first single conversion with channel change in flight
		wr(sar_ctl_pkg::MUX_IDX, 8'h85);
		lfsr = step(lfsr);
		r = lfsr[9:0];
		SAR_RESULT <= r;
		wr(sar_ctl_pkg::CTRLA_IDX, EN | GO);
		wait_start(400);
		wr(sar_ctl_pkg::MUX_IDX, 8'h01);
		tick(4);
		chk("chan locked", 6'h05, FRONT_END.chan);
		wait_end();
		chk("first length", 1, len >= 25 * P - P && len <= 25 * P + P);
		chk("chan applied", 6'h01, FRONT_END.chan);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | DN, "done set start clear");
		rdc(sar_ctl_pkg::RESL_IDX, exp_lo(r, 1'b0), "right low");
		rdc(sar_ctl_pkg::RESH_IDX, exp_hi(r, 1'b0), "right high");
		// lock after low read, left adjusted
		wr(sar_ctl_pkg::CTRLB_IDX, LA);
		lfsr = step(lfsr);
		r = lfsr[9:0];
		SAR_RESULT <= r;
		wr(sar_ctl_pkg::CTRLA_IDX, EN | DN | GO);
		wait_start(400);
		wait_end();
		chk("normal length", 1, len >= 13 * P - P && len <= 13 * P + P);
		rdc(sar_ctl_pkg::RESL_IDX, exp_lo(r, 1'b1), "left low");
		SAR_RESULT <= ~r;
		wr(sar_ctl_pkg::CTRLA_IDX, EN | DN | GO);
		wait_start(400);
		wait_end();
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | DN, "flag while locked");
		rdc(sar_ctl_pkg::RESH_IDX, exp_hi(r, 1'b1), "locked high");
		rdc(sar_ctl_pkg::RESL_IDX, exp_lo(r, 1'b1), "locked low");
		wr(sar_ctl_pkg::CTRLA_IDX, EN | IE | DN | GO);
		wait_start(400);
		wait_end();
		chk("irq raised", 1, IRQ);
		@(posedge CLK);
		IRQ_ACK <= 1'b1;
		@(posedge CLK);
		IRQ_ACK <= 1'b0;
		tick(2);
		chk("irq serviced", 0, IRQ);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | IE, "flag serviced");
		wr(sar_ctl_pkg::CTRLA_IDX, EN | GO);
		wait_start(400);
		wait_end();
		chk("irq masked", 0, IRQ);
		wr(sar_ctl_pkg::CTRLA_IDX, EN);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | DN, "write zero keeps");
		wr(sar_ctl_pkg::CTRLA_IDX, EN | DN);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN, "write one clears");
		wr(sar_ctl_pkg::CTRLB_IDX, 8'h03);
		wr(sar_ctl_pkg::CTRLA_IDX, EN | AU);
		trig(8'h20);
		no_start(20);
		trig(8'h28);
		wait_start(8);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | AU | GO, "busy reads start");
		trig(8'h20);
		trig(8'h28);
		wait_end();
		no_start(40);
		wr(sar_ctl_pkg::CTRLA_IDX, EN | AU | DN | GO);
		wait_start(400);
		wait_end();
		// flag cleared by stimulus, then a fresh edge
		trig(8'h00);
		trig(8'h08);
		wait_start(8);
		wait_end();
		wr(sar_ctl_pkg::CTRLB_IDX, {5'h00, sar_ctl_pkg::TRIG_FREE});
		trig(8'h00);
		wr(sar_ctl_pkg::CTRLA_IDX, EN | AU | GO);
		s0 = starts;
		tick(120);
		chk("free run count", 1, starts - s0 >= 4);
		rdc(sar_ctl_pkg::CTRLA_IDX, EN | AU | GO | DN, "free run start");
		wr(sar_ctl_pkg::CTRLA_IDX, 8'h00);
		tick(4);
		chk("busy after disable", 0, CONV_BUSY);
		no_start(40);
		results();
	end
endmodule // tb
